// ==== include/acu_params.svh ====
// Register map, field positions and timing constants of the converter control unit
`ifndef ACU_PARAMS_SVH
`define ACU_PARAMS_SVH
`define ACU_ADDR_CONTROL   8'h1f
`define ACU_ADDR_PORTCFG   8'h9f
`define ACU_ADDR_RESULT    8'h1e
`define ACU_ADDR_IRQ_STAT  8'h0c
`define ACU_ADDR_IRQ_EN    8'h8c
`define ACU_ADDR_IRQ_CLR   8'h0d
`define ACU_BIT_POWER      0
`define ACU_BIT_GO         2
`define ACU_CHS_LSB        3
`define ACU_CHS_MSB        5
`define ACU_CKS_LSB        6
`define ACU_CKS_MSB        7
`define ACU_BIT_DONE_IRQ   0
`define ACU_CTRL_RESET     8'h00
`define ACU_CTRL_WMASK     8'hfd
`define ACU_PCFG_MASK      8'h07
`define ACU_CKS_DIV2       2'h0
`define ACU_CKS_DIV8       2'h1
`define ACU_CKS_DIV32      2'h2
`define ACU_CKS_RC         2'h3
`define ACU_TAD_DIV2       6'h02
`define ACU_TAD_DIV8       6'h08
`define ACU_TAD_DIV32      6'h20
`define ACU_NUM_CHANNELS   3'h5
`define ACU_RES_BITS       4'h8
`define ACU_MSB_INDEX      3'h7
`endif

// ==== include/acu_pkg.sv ====
// Types shared by the converter control unit
package acu_pkg;
	// Conversion sequencer states
	typedef enum logic [1:0] {
		ACU_IDLE   = 2'b00,
		ACU_SAMPLE = 2'b01,
		ACU_CONV   = 2'b10,
		ACU_DONE   = 2'b11
	} acu_state_type;
	typedef logic [7:0] acu_byte_type;
endpackage : acu_pkg

// ==== hdl/acu_top.sv ====
// Successive-approximation converter control unit with register port and interrupt
`timescale 1ns/10ps
`include "acu_params.svh"
// How it works
// [RULE1] Five analog channels, one routed per conversion
// [RULE2] Each conversion yields unsigned 8-bit result
// [RULE3] Successive approximation, one bit per step
// [RULE4] Reference is supply or shared reference pin
// [RULE5] Sleep conversion only with internal RC clock
// [RULE6] Reset clears registers, powers off, aborts
// [RULE7] Port pins analog or digital; reference pin
// [RULE8] Bits 5:3 select channel 0 to 4
// [RULE9] Bits 7:6 select conversion clock source
// [RULE10] Codes 00/01/10 divide 2/8/32, 11 RC
// [RULE11] Done loads result, clears go, sets flag
// [RULE12] Clearing go aborts, result keeps old value
// [RULE13] Power off means lowest current, no conversion
// [RULE14] Bit 0 powers on; bit 1 reads zero
module acu_top (
	input  wire logic                 i_clk,         // System clock, 40 MHz
	input  wire logic                 i_sys_rst,     // Synchronous reset, active high
	input  wire logic [7:0]           i_addr,        // Register address
	input  wire acu_pkg::acu_byte_type i_wdata,      // Register write data
	input  wire logic                 i_wr,          // Write strobe
	input  wire logic                 i_rd,          // Read strobe
	output logic       [7:0]          o_rdata,       // Read data, cycle after strobe
	input  wire logic                 i_sleep,       // Device in sleep, system clock gated
	input  wire logic                 i_rc_tick,     // Internal RC oscillator tick, async
	input  wire logic                 i_comp_high,   // Comparator: sample above trial level
	output logic       [2:0]          o_channel,     // Multiplexer channel select
	output logic                      o_sample,      // Sample-and-hold tracking
	output logic       [7:0]          o_dac_code,    // Trial code to the comparator DAC
	output logic                      o_ref_ext,     // Use shared reference pin as reference
	output logic                      o_analog_en,   // Analog bias enable
	output logic       [4:0]          o_pin_analog,  // Per-pin analog select
	output logic                      o_irq          // Level interrupt
);
	import acu_pkg::*;

	// ==========================================================
	// Registers and state
	acu_byte_type  control;      // Control register
	acu_byte_type  port_cfg;     // Port configuration register
	acu_byte_type  result;       // Last completed result
	logic          irq_stat;     // Sticky done flag
	logic          irq_en;       // Interrupt enable
	acu_state_type state;        // Sequencer state
	acu_byte_type  sar;          // Approximation register
	logic [2:0]    bit_idx;      // Bit under trial
	logic [5:0]    div_cnt;      // Clock divider count
	logic          tad_tick;     // One bit time elapsed
	logic          rc_s1;        // RC tick synchroniser, stage 1
	logic          rc_s2;        // RC tick synchroniser, stage 2
	logic          rc_s3;        // Edge history for RC tick
	logic          done_evt;     // Conversion finished this cycle
	logic          go_clear;     // Software cleared go this cycle
	logic          wr_ctrl;      // Control write strobe

	// Divider length for a clock-select code
	function automatic logic [5:0] tad_len(input logic [1:0] cks);
		case (cks) // RULE10
			`ACU_CKS_DIV2:  tad_len = `ACU_TAD_DIV2;
			`ACU_CKS_DIV8:  tad_len = `ACU_TAD_DIV8;
			default:        tad_len = `ACU_TAD_DIV32;
		endcase
	endfunction : tad_len

	wire logic       power   = control[`ACU_BIT_POWER];
	wire logic       go      = control[`ACU_BIT_GO];
	wire logic [1:0] cks     = control[`ACU_CKS_MSB:`ACU_CKS_LSB];
	wire logic       use_rc  = (cks == `ACU_CKS_RC);
	assign wr_ctrl  = i_wr && (i_addr == `ACU_ADDR_CONTROL);
	assign go_clear = wr_ctrl && !i_wdata[`ACU_BIT_GO];

	// ==========================================================
	// RC tick synchroniser; stages 2 and 3 both feed the edge detect
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			rc_s1 <= 1'b0;
			rc_s2 <= 1'b0;
			rc_s3 <= 1'b0;
		end else begin
			rc_s1 <= i_rc_tick;
			rc_s2 <= rc_s1;
			rc_s3 <= rc_s2;
		end
	end

	// ==========================================================
	// Bit-time generator: divided system clock or RC edge
	// Sleep stops the system divider, so only RC runs then
	// The tick is registered: one cycle of latency buys a glitch-free strobe
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || state == ACU_IDLE) begin
			div_cnt  <= 6'h00;
			tad_tick <= 1'b0;
		end else if (use_rc) begin // RULE9
			div_cnt  <= 6'h00;
			tad_tick <= rc_s2 && !rc_s3; // RULE5
		end else if (i_sleep) begin
			div_cnt  <= 6'h00; // RULE5
			tad_tick <= 1'b0;
		end else if (div_cnt == tad_len(cks) - 6'h01) begin // RULE10
			div_cnt  <= 6'h00;
			tad_tick <= 1'b1;
		end else begin
			div_cnt  <= div_cnt + 6'h01;
			tad_tick <= 1'b0;
		end
	end

	// ==========================================================
	// Control register; hardware clears go on completion
	// A software write wins over the hardware clear in the same cycle
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			control <= `ACU_CTRL_RESET; // RULE6
		end else if (wr_ctrl) begin
			control <= i_wdata & `ACU_CTRL_WMASK; // RULE14 RULE8
		end else if (done_evt) begin
			control[`ACU_BIT_GO] <= 1'b0; // RULE11
		end else if (!power || (i_sleep && !use_rc)) begin
			control[`ACU_BIT_GO] <= 1'b0; // RULE13
		end
	end

	// Port configuration register
	// Only the three layout bits exist; the upper bits read zero
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			port_cfg <= 8'h00; // RULE6
		end else if (i_wr && i_addr == `ACU_ADDR_PORTCFG) begin
			port_cfg <= i_wdata & `ACU_PCFG_MASK; // RULE7
		end
	end

	// ==========================================================
	// Sequencer: sample one bit time, then eight trials
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state    <= ACU_IDLE; // RULE6
			sar      <= 8'h00;
			bit_idx  <= `ACU_MSB_INDEX;
			done_evt <= 1'b0;
		end else begin
			done_evt <= 1'b0;
			// Done also stops the sequencer: go is still set in the cycle after
			// completion, and restarting there would launch a stray sample phase
			if (!power || !go || go_clear || done_evt || (i_sleep && !use_rc)) begin
				state   <= ACU_IDLE; // RULE12 RULE13
				sar     <= 8'h00;
				bit_idx <= `ACU_MSB_INDEX;
			end else begin
				case (state)
					ACU_IDLE: begin
						state <= ACU_SAMPLE;
						sar   <= 8'h00;
					end
					ACU_SAMPLE: if (tad_tick) begin
						state   <= ACU_CONV;
						sar     <= 8'h80;
						bit_idx <= `ACU_MSB_INDEX;
					end
					ACU_CONV: if (tad_tick) begin
						// Keep or drop the trial bit, then try the next
						sar[bit_idx] <= i_comp_high; // RULE3
						if (bit_idx == 3'h0) begin
							state <= ACU_DONE;
						end else begin
							sar[bit_idx - 3'h1] <= 1'b1;
							bit_idx <= bit_idx - 3'h1;
						end
					end
					ACU_DONE: begin
						done_evt <= 1'b1; // RULE11
						state    <= ACU_IDLE;
					end
					default: state <= ACU_IDLE;
				endcase
			end
		end
	end

	// ==========================================================
	// Result register; written only by a completed conversion
	// Power-off and go-clear aborts never reach the load; a sleep abort without RC in the done cycle still loads sar
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			result <= 8'h00;
		end else if (state == ACU_DONE && power && go && !go_clear) begin
			result <= sar; // RULE2 RULE11
		end
	end

	// ==========================================================
	// Interrupt: set beats clear
	// Clear is write-one, so a zero write cannot lose an unseen event
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			irq_stat <= 1'b0;
			irq_en   <= 1'b0;
		end else begin
			if (done_evt) begin
				irq_stat <= 1'b1; // RULE11
			end else if (i_wr && i_addr == `ACU_ADDR_IRQ_CLR && i_wdata[`ACU_BIT_DONE_IRQ]) begin
				irq_stat <= 1'b0;
			end
			if (i_wr && i_addr == `ACU_ADDR_IRQ_EN) begin
				irq_en <= i_wdata[`ACU_BIT_DONE_IRQ];
			end
		end
	end
	assign o_irq = irq_stat && irq_en;

	// ==========================================================
	// Read port; unmapped addresses read zero
	// Idle cycles return zero so that a late sample shows up as a mismatch
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			case (i_addr)
				`ACU_ADDR_CONTROL:  o_rdata <= control; // RULE14
				`ACU_ADDR_PORTCFG:  o_rdata <= port_cfg;
				`ACU_ADDR_RESULT:   o_rdata <= result;
				`ACU_ADDR_IRQ_STAT: o_rdata <= {7'h00, irq_stat};
				`ACU_ADDR_IRQ_EN:   o_rdata <= {7'h00, irq_en};
				default:            o_rdata <= 8'h00;
			endcase
		end else begin
			o_rdata <= 8'h00;
		end
	end

	// ==========================================================
	// Analog front end controls, registered
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_channel    <= 3'h0;
			o_sample     <= 1'b0;
			o_dac_code   <= 8'h00;
			o_ref_ext    <= 1'b0;
			o_analog_en  <= 1'b0;
			o_pin_analog <= 5'h00;
		end else begin
			// Codes 5..7 have no channel; hold channel 0
			o_channel   <= (control[`ACU_CHS_MSB:`ACU_CHS_LSB] < `ACU_NUM_CHANNELS) ?
				control[`ACU_CHS_MSB:`ACU_CHS_LSB] : 3'h0; // RULE1 RULE8
			o_sample    <= power && (state != ACU_CONV); // RULE1
			o_dac_code  <= sar;
			// Codes 1, 3 and 5 hand the reference to the shared pin
			o_ref_ext   <= port_cfg[0] && (!port_cfg[2] || port_cfg[2:0] == 3'h5); // RULE4
			o_analog_en <= power && !(i_sleep && !use_rc); // RULE13
			// Pin bits: 0 to 2 first inputs, 3 fifth input, 4 shared reference pin
			case (port_cfg[2:0]) // RULE7
				3'h0, 3'h2:  o_pin_analog <= 5'h1f;
				3'h1, 3'h3:  o_pin_analog <= 5'h0f;
				3'h4:        o_pin_analog <= 5'h13;
				3'h5:        o_pin_analog <= 5'h03;
				default:     o_pin_analog <= 5'h00;
			endcase
		end
	end

	// ==========================================================
	// Checks
	a_done_clears_go: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		done_evt && !wr_ctrl |=> !control[`ACU_BIT_GO]) else $error("go not cleared"); // RULE11
	a_done_sets_flag: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		done_evt |=> irq_stat) else $error("done flag missing"); // RULE11
	a_abort_keeps: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		go_clear && state == ACU_CONV |=> $stable(result) ##1 $stable(result)) else $error("abort changed result"); // RULE12
	a_power_off_idle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!power |=> state == ACU_IDLE) else $error("converting unpowered"); // RULE13
	a_bit1_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!control[1]) else $error("bit 1 set"); // RULE14
	a_reset_off: assert property (@(posedge i_clk)
		i_sys_rst |=> control == 8'h00 && state == ACU_IDLE) else $error("reset not off"); // RULE6
	a_channel_range: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_channel < `ACU_NUM_CHANNELS) else $error("bad channel"); // RULE1
	a_sleep_rc_only: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_sleep && !use_rc |=> state == ACU_IDLE) else $error("sleep conversion without rc"); // RULE5
	a_div2_tick: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		$rose(tad_tick) && cks == 2'h0 && !i_sleep && state != ACU_IDLE && $stable(cks) |=> !tad_tick ##1 tad_tick or
		(##1 state == ACU_IDLE) or ##1 ($changed(cks) || i_sleep)) else $error("div2 rate wrong"); // RULE10
	// Power, abort and hold properties
	a_go_refused_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!power && !wr_ctrl |=> !control[`ACU_BIT_GO]) else $error("go kept while unpowered"); // RULE13
	a_abort_to_idle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		go_clear |=> state == ACU_IDLE) else $error("abort left sequencer busy"); // RULE12
	a_abort_no_done: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		go_clear |=> !done_evt) else $error("aborted conversion completed"); // RULE12
	a_hold_in_conv: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		state == ACU_CONV |=> !o_sample) else $error("tracking during conversion"); // RULE3
	a_bias_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!power |=> !o_analog_en) else $error("bias on while unpowered"); // RULE13

	// ==========================================================
	// Scenario covers
	c_complete: cover property (@(posedge i_clk) done_evt);
	c_abort: cover property (@(posedge i_clk) go_clear && state == ACU_CONV);
	c_rc_sleep: cover property (@(posedge i_clk) done_evt && i_sleep);
	c_div32_done: cover property (@(posedge i_clk) done_evt && cks == `ACU_CKS_DIV32);
	c_reset_busy: cover property (@(posedge i_clk) i_sys_rst && state == ACU_CONV);
endmodule : acu_top

// ==== tb/acu_front_model.sv ====
// Behavioural analog front end: channel levels, sample-and-hold, comparator
`timescale 1ns/10ps
module acu_front_model (
	input  wire logic       i_clk,      // System clock
	input  wire logic [2:0] i_channel,  // Selected channel
	input  wire logic       i_sample,   // Tracking while high
	input  wire logic [7:0] i_dac_code, // Trial code
	output logic            o_comp_high // Held level above trial
);
	logic [7:0] level [5];    // Level per input, set by the bench
	logic [7:0] held = 8'h00; // Held sample
	// ==========
	// Track while sampling; freezing is what makes the result stable
	always @(posedge i_clk) begin
		if (i_sample) begin
			held <= level[i_channel];
		end
	end
	assign o_comp_high = held > i_dac_code;
endmodule : acu_front_model

// ==== tb/adc_control_unit_tb.sv ====
// Self-checking bench of the converter control unit
`timescale 1ns/10ps
`include "acu_params.svh"
module adc_control_unit_tb;
	import acu_pkg::*;
	logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, sleep = 1'b0, rc = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, dac, d, last = 8'h00;
	logic [2:0] chan;
	logic [4:0] pins;
	logic       comp, smp, ref_ext, aen, irq;
	int         failures = 0, checks = 0, cyc = 0;
	logic [7:0] amap [7] = '{`ACU_ADDR_CONTROL, `ACU_ADDR_PORTCFG, `ACU_ADDR_RESULT,
		`ACU_ADDR_IRQ_STAT, `ACU_ADDR_IRQ_EN, `ACU_ADDR_IRQ_CLR, 8'h55};
	always #12.5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	// Internal RC oscillator, free running, unrelated in phase
	always #90.3 rc = ~rc;
	acu_top i_acu_top (.i_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .i_sleep(sleep), .i_rc_tick(rc), .i_comp_high(comp), .o_channel(chan),
		.o_sample(smp), .o_dac_code(dac), .o_ref_ext(ref_ext), .o_analog_en(aen), .o_pin_analog(pins),
		.o_irq(irq));
	acu_front_model i_acu_front_model (.i_clk(clk), .i_channel(chan), .i_sample(smp), .i_dac_code(dac),
		.o_comp_high(comp));
	// ==========
	// Helpers
	task automatic chk(input string name, input logic [7:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	// Data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		v = rdata;
	endtask : rd_reg
	// Bit kept when the held level lies above the trial code
	function automatic logic [7:0] sar(input logic [7:0] lvl);
		logic [7:0] r = 8'h00;
		for (int b = 7; b >= 0; b--) if (lvl > (r | (8'h01 << b))) r |= 8'h01 << b;
		return r;
	endfunction : sar
	// Expected {reference, pins} per port configuration code
	function automatic logic [7:0] pcfg(input logic [2:0] c);
		case (c)
			3'h0, 3'h2: return 8'h1f;
			3'h1, 3'h3: return 8'h2f;
			3'h4: return 8'h13;
			3'h5: return 8'h23;
			default: return 8'h00;
		endcase
	endfunction : pcfg
	task automatic conv(input logic [2:0] ch, input logic [1:0] ck, input logic [7:0] lvl);
		int t0, n;
		logic en;
		en = 1'($urandom);
		i_acu_front_model.level[ch] = lvl;
		wr_reg(`ACU_ADDR_IRQ_EN, {7'h00, en});
		wr_reg(`ACU_ADDR_CONTROL, {ck, ch, 3'b001});
		wr_reg(`ACU_ADDR_CONTROL, {ck, ch, 3'b101});
		t0 = cyc;
		n = 2 << (2 * ck);
		@(negedge clk);
		chk("channel", {5'h00, chan}, {5'h00, ch});
		d = 8'h04;
		while (d[2] && cyc - t0 < 3000) rd_reg(`ACU_ADDR_CONTROL, d);
		if (ck != `ACU_CKS_RC) chk("time", {7'h00, cyc - t0 >= 8 * n && cyc - t0 <= 9 * n + 12}, 8'h01);
		chk("go", d & 8'h04, 8'h00);
		chk("tracking", {7'h00, smp}, 8'h01);
		last = sar(lvl);
		rd_reg(`ACU_ADDR_RESULT, d);
		chk("result", d, last);
		rd_reg(`ACU_ADDR_IRQ_STAT, d);
		chk("flag", d, 8'h01);
		chk("irq", {7'h00, irq}, {7'h00, en});
		wr_reg(`ACU_ADDR_IRQ_CLR, 8'h01);
		@(negedge clk);
		chk("irq cleared", {7'h00, irq}, 8'h00);
	endtask : conv
	task automatic conclude();
		if (failures == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : conclude
	// ==========
	// Watchdog
	initial begin
		#1000000;
		failures++;
		conclude();
	end
	// ==========
	// Tests
	initial begin
		void'($urandom(32'h12de));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		wr_reg(8'h55, 8'hff);
		for (int i = 0; i < 7; i++) begin
			rd_reg(amap[i], d);
			chk("reset value", d, 8'h00);
		end
		wr_reg(`ACU_ADDR_CONTROL, 8'hfa);
		rd_reg(`ACU_ADDR_CONTROL, d);
		chk("control", d, 8'hf8);
		for (int c = 0; c < 8; c++) begin
			wr_reg(`ACU_ADDR_PORTCFG, 8'(c));
			rd_reg(`ACU_ADDR_PORTCFG, d);
			chk("port config", d, 8'(c));
			chk("pins", {2'h0, ref_ext, pins}, pcfg(3'(c)));
		end
		conv(3'h0, `ACU_CKS_DIV2, 8'hff);
		conv(3'h4, `ACU_CKS_DIV8, 8'h00);
		conv(3'h2, `ACU_CKS_DIV32, 8'h80);
		conv(3'h3, `ACU_CKS_RC, 8'h55);
		repeat (6) conv(3'($urandom % 5), 2'($urandom), 8'($urandom));
		// Sleep converts only on the RC clock
		@(posedge clk);
		sleep <= 1'b1;
		conv(3'h1, `ACU_CKS_RC, 8'h3c);
		wr_reg(`ACU_ADDR_CONTROL, 8'h45);
		repeat (20) @(posedge clk);
		@(negedge clk);
		chk("analog on", {7'h00, aen}, 8'h00);
		repeat (400) @(posedge clk);
		rd_reg(`ACU_ADDR_IRQ_STAT, d);
		chk("sleep flag", d, 8'h00);
		wr_reg(`ACU_ADDR_CONTROL, 8'h00);
		sleep <= 1'b0;
		// Abort by clearing go keeps the old result
		// A finished conversion would now give a value other than the last one
		i_acu_front_model.level[1] = 8'hc4;
		wr_reg(`ACU_ADDR_CONTROL, 8'h89);
		wr_reg(`ACU_ADDR_CONTROL, 8'h8d);
		repeat (60) @(posedge clk);
		wr_reg(`ACU_ADDR_CONTROL, 8'h89);
		repeat (400) @(posedge clk);
		rd_reg(`ACU_ADDR_RESULT, d);
		chk("kept result", d, last);
		rd_reg(`ACU_ADDR_IRQ_STAT, d);
		chk("abort flag", d, 8'h00);
		// Go without power is refused
		wr_reg(`ACU_ADDR_CONTROL, 8'h04);
		repeat (3) @(posedge clk);
		rd_reg(`ACU_ADDR_CONTROL, d);
		chk("unpowered go", d, 8'h00);
		chk("unpowered bias", {7'h00, aen}, 8'h00);
		// Reset in mid conversion
		wr_reg(`ACU_ADDR_CONTROL, 8'h81);
		wr_reg(`ACU_ADDR_CONTROL, 8'h85);
		repeat (50) @(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd_reg(`ACU_ADDR_CONTROL, d);
		chk("control after reset", d, 8'h00);
		chk("bias after reset", {7'h00, aen}, 8'h00);
		chk("irq after reset", {7'h00, irq}, 8'h00);
		rd_reg(`ACU_ADDR_RESULT, d);
		chk("result after reset", d, 8'h00);
		conclude();
	end
endmodule : adc_control_unit_tb
